//--- hdl/tovl_row0_ctrl.sv
// Text overlay row-0 control: registers, sync handling, position counters and dot output.
// Assumes sync inputs synchronous to aclk and an external glyph source that
// answers the glyph coordinates with the current and the line-above dot.
//
// How it works
// (R01) Three colour bits drive colour outputs.
// (R02) Raster blank bit forces blank output high.
// (R03) Blank force released at vertical sync end.
// (R04) Rounding bit inserts diagonal half dots.
// (R05) Rounding continues across character cell edges.
// (R06) Standby bit stops the dot oscillator.
// (R07) Vertical polarity bit selects active level.
// (R08) Horizontal polarity bit selects active level.
// (R09) Two size bits scale row zero.
// (R10) Six bits give row vertical start.
// (R11) Display bit gates colour and blank outputs.
// (R12) Background bit draws box behind characters.
// (R13) Six bits give row horizontal start.
// (R14) Horizontal position counts only on dot clock.
// (R15) Registers sit at consecutive indices.
// (R16) Registers read/write, zero after reset.
// (R17) Horizontal counter runs after sync, cleared during.
// (R18) Vertical counter counts lines, cleared by vsync.
// (R19) Oscillator runs from sync end to start.
// (R20) Dots start at vertical and horizontal match.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tovl_params.svh"

module tovl_row0_ctrl #(
	parameter int ADDR_W = 12,
	parameter int DOT_DIV = `TOVL_DOT_DIV,
	parameter int ROW_CHARS = `TOVL_ROW_CHARS,
	parameter int CELL_DOTS = `TOVL_CELL_DOTS,
	parameter int CELL_LINES = `TOVL_CELL_LINES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic vertical_sync_in,
	input wire logic horizontal_sync_in,
	input wire logic glyph_dot_in,
	input wire logic glyph_dot_above_in,
	output logic [6:0] glyph_x,
	output logic [3:0] glyph_line,
	output logic colour_out_a,
	output logic colour_out_b,
	output logic colour_out_c,
	output logic video_blank_out,
	output logic overlay_dot_clock
);
	logic [7:0] general_q, row0_sv_q, row0_hb_q;
	logic dot_tick, dot_first_half, dot_running;

	// Register slave; indices consecutive from the general register
	// R15 consecutive map
	tovl_axil_regs #(
		.ADDR_W(ADDR_W)
	) u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.general_q(general_q),
		.row0_sv_q(row0_sv_q),
		.row0_hb_q(row0_hb_q)
	);

	// Field views of the registers
	logic [2:0] colour_select;
	logic raster_blank_force, round_enable, overlay_standby;
	logic vertical_sync_polarity, horizontal_sync_polarity;
	tovl_pkg::tovl_size_type row0_size;
	logic [5:0] row0_vertical_pos, row0_horizontal_pos;
	logic row0_display_enable, row0_background_enable;
	assign colour_select = general_q[`TOVL_GEN_COLOUR_HI:`TOVL_GEN_COLOUR_LO];
	assign raster_blank_force = general_q[`TOVL_GEN_RASTER_BLANK_FORCE];
	assign round_enable = general_q[`TOVL_GEN_ROUND];
	assign overlay_standby = general_q[`TOVL_GEN_OVERLAY_STANDBY];
	assign vertical_sync_polarity = general_q[`TOVL_GEN_VPOL];
	assign horizontal_sync_polarity = general_q[`TOVL_GEN_HPOL];
	assign row0_size = row0_sv_q[`TOVL_SV_SIZE_HI:`TOVL_SV_SIZE_LO];
	assign row0_vertical_pos = row0_sv_q[`TOVL_SV_VPOS_HI:`TOVL_SV_VPOS_LO];
	assign row0_display_enable = row0_hb_q[`TOVL_HB_DISP];
	assign row0_background_enable = row0_hb_q[`TOVL_HB_BGND];
	assign row0_horizontal_pos = row0_hb_q[`TOVL_HB_HPOS_HI:`TOVL_HB_HPOS_LO];

	// Sync inputs corrected for their programmed active level
	logic hs_active, vs_active;
	// R07 vertical polarity
	assign vs_active = (vertical_sync_in == vertical_sync_polarity);
	// R08 horizontal polarity
	assign hs_active = (horizontal_sync_in == horizontal_sync_polarity);

	// Dot oscillator, held off in standby
	tovl_dot_clock #(
		.DIV(DOT_DIV)
	) u_dot (
		.aclk(aclk),
		.aresetn(aresetn),
		.osc_enable(!overlay_standby),
		.hs_active(hs_active),
		.dot_tick(dot_tick),
		.dot_first_half(dot_first_half),
		.running(dot_running)
	);

	// Position counters, row window and blanking hold
	logic hs_prev_q, vs_prev_q, blank_hold_q, blank_hold_d;
	logic [9:0] hcnt_q, hcnt_d;
	logic [8:0] vcnt_q, vcnt_d;
	logic vrow_q, vrow_d, hrow_q, hrow_d;
	logic [1:0] ysub_q, ysub_d, xsub_q, xsub_d;
	logic [3:0] yline_q, yline_d;
	logic [6:0] xdot_q, xdot_d;
	logic left_q, left_d, upleft_q, upleft_d;
	logic hs_lead, vs_trail;
	assign hs_lead = hs_active && !hs_prev_q;
	assign vs_trail = vs_prev_q && !vs_active;

	always_comb begin
		hcnt_d = hcnt_q;
		vcnt_d = vcnt_q;
		vrow_d = vrow_q;
		hrow_d = hrow_q;
		ysub_d = ysub_q;
		yline_d = yline_q;
		xsub_d = xsub_q;
		xdot_d = xdot_q;
		left_d = left_q;
		upleft_d = upleft_q;
		blank_hold_d = blank_hold_q;
		// R02 force blank
		if (raster_blank_force) begin
			blank_hold_d = 1'b1;
		// R03 release at vsync end
		end else if (vs_trail) begin
			blank_hold_d = 1'b0;
		end
		// R18 line counter
		if (vs_active) begin
			vcnt_d = 9'h000;
			vrow_d = 1'b0;
		end else if (hs_lead) begin
			vcnt_d = vcnt_q + 9'h001;
			// R10 vertical start, R09 size scales lines
			if (vcnt_q + 9'h001 == {3'b000, row0_vertical_pos}) begin
				vrow_d = 1'b1;
				ysub_d = 2'b00;
				yline_d = 4'h0;
			end else if (vrow_q) begin
				if (ysub_q == row0_size) begin
					ysub_d = 2'b00;
					yline_d = yline_q + 4'h1;
					if (yline_q == 4'(CELL_LINES - 1)) begin
						vrow_d = 1'b0;
					end
				end else begin
					ysub_d = ysub_q + 2'b01;
				end
			end
		end
		// R17 cleared during sync
		if (hs_active) begin
			hcnt_d = 10'h000;
			hrow_d = 1'b0;
		// R14 counts dot periods
		end else if (dot_tick) begin
			hcnt_d = hcnt_q + 10'h001;
			// R13 horizontal start, R20 start at match
			if (hcnt_q == {4'h0, row0_horizontal_pos}) begin
				hrow_d = vrow_q;
				xsub_d = 2'b00;
				xdot_d = 7'h00;
				left_d = 1'b0;
				upleft_d = 1'b0;
			end else if (hrow_q) begin
				if (xsub_q == row0_size) begin
					xsub_d = 2'b00;
					xdot_d = xdot_q + 7'h01;
					// R05 neighbours carried over cell edges
					left_d = glyph_dot_in;
					upleft_d = glyph_dot_above_in;
					if (xdot_q == 7'(ROW_CHARS * CELL_DOTS - 1)) begin
						hrow_d = 1'b0;
					end
				end else begin
					xsub_d = xsub_q + 2'b01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_prev_q <= 1'b0;
			vs_prev_q <= 1'b0;
			blank_hold_q <= 1'b0;
			hcnt_q <= 10'h000;
			vcnt_q <= 9'h000;
			vrow_q <= 1'b0;
			hrow_q <= 1'b0;
			ysub_q <= 2'b00;
			yline_q <= 4'h0;
			xsub_q <= 2'b00;
			xdot_q <= 7'h00;
			left_q <= 1'b0;
			upleft_q <= 1'b0;
		end else begin
			hs_prev_q <= hs_active;
			vs_prev_q <= vs_active;
			blank_hold_q <= blank_hold_d;
			hcnt_q <= hcnt_d;
			vcnt_q <= vcnt_d;
			vrow_q <= vrow_d;
			hrow_q <= hrow_d;
			ysub_q <= ysub_d;
			yline_q <= yline_d;
			xsub_q <= xsub_d;
			xdot_q <= xdot_d;
			left_q <= left_d;
			upleft_q <= upleft_d;
		end
	end

	// Dot, half dot and output decision
	logic window, half_dot, dot_on;
	logic [2:0] colour_d, colour_q;
	logic vob_d, vob_q;
	assign window = vrow_q && hrow_q && dot_running;
	// R04 half dot at diagonal contact
	assign half_dot = round_enable && !glyph_dot_in && left_q && glyph_dot_above_in && !upleft_q;
	assign dot_on = window && (glyph_dot_in || (half_dot && dot_first_half));

	always_comb begin
		colour_d = 3'b000;
		vob_d = 1'b0;
		// R11 display enable gates outputs
		if (row0_display_enable) begin
			// R01 colour bits to outputs
			colour_d = dot_on ? colour_select : 3'b000;
			// R12 background box
			vob_d = dot_on || (window && row0_background_enable);
		end
		if (blank_hold_q) begin
			vob_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			colour_q <= 3'b000;
			vob_q <= 1'b0;
		end else begin
			colour_q <= colour_d;
			vob_q <= vob_d;
		end
	end

	assign colour_out_a = colour_q[0];
	assign colour_out_b = colour_q[1];
	assign colour_out_c = colour_q[2];
	assign video_blank_out = vob_q;
	assign overlay_dot_clock = dot_running && dot_first_half;
	assign glyph_x = xdot_q;
	assign glyph_line = yline_q;

	property p_force_blank;
		@(posedge aclk) disable iff (!aresetn)
		raster_blank_force ##1 raster_blank_force |=> video_blank_out;
	endproperty
	a_force_blank: assert property (p_force_blank) // (R02)
		else $error("blank output low while forced");

	property p_blank_release;
		@(posedge aclk) disable iff (!aresetn)
		(blank_hold_q && !raster_blank_force && !vs_trail) |=> blank_hold_q;
	endproperty
	a_blank_release: assert property (p_blank_release) // (R03)
		else $error("blank hold released outside vsync end");

	property p_display_off;
		@(posedge aclk) disable iff (!aresetn)
		(!row0_display_enable && !blank_hold_q) |=> (!video_blank_out && colour_q == 3'b000);
	endproperty
	a_display_off: assert property (p_display_off) // (R11)
		else $error("outputs active with display disabled");

	property p_hcnt_cleared;
		@(posedge aclk) disable iff (!aresetn)
		hs_active |=> hcnt_q == 10'h000;
	endproperty
	a_hcnt_cleared: assert property (p_hcnt_cleared) // (R17)
		else $error("horizontal counter not cleared in sync");

	property p_hcnt_dot_only;
		@(posedge aclk) disable iff (!aresetn)
		(!dot_tick && !hs_active) |=> $stable(hcnt_q);
	endproperty
	a_hcnt_dot_only: assert property (p_hcnt_dot_only) // (R14)
		else $error("horizontal counter moved without dot tick");

	property p_vcnt_line;
		@(posedge aclk) disable iff (!aresetn)
		(hs_lead && !vs_active) |=> vcnt_q == $past(vcnt_q) + 9'h001;
	endproperty
	a_vcnt_line: assert property (p_vcnt_line) // (R18)
		else $error("vertical counter missed a line");

	property p_colour_source;
		@(posedge aclk) disable iff (!aresetn)
		(dot_on && row0_display_enable) |=> colour_q == $past(colour_select);
	endproperty
	a_colour_source: assert property (p_colour_source) // (R01)
		else $error("colour outputs differ from colour select");

endmodule

//--- hdl/tovl_params.svh
// Register map, field positions, reset values and timing of the text overlay row-0 control.
// Included by the three design modules of the block; definitions only.
`ifndef TOVL_PARAMS_SVH
`define TOVL_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define TOVL_IDX_GENERAL 8'h40
`define TOVL_IDX_ROW0_SV 8'h41
`define TOVL_IDX_ROW0_HB 8'h42

// Register reset values
`define TOVL_RST_GENERAL 8'h00
`define TOVL_RST_ROW0_SV 8'h00
`define TOVL_RST_ROW0_HB 8'h00

// General control fields
`define TOVL_GEN_COLOUR_HI 7
`define TOVL_GEN_COLOUR_LO 5
`define TOVL_GEN_RASTER_BLANK_FORCE 4
`define TOVL_GEN_ROUND 3
`define TOVL_GEN_OVERLAY_STANDBY 2
`define TOVL_GEN_VPOL 1
`define TOVL_GEN_HPOL 0

// Row-0 size / vertical fields
`define TOVL_SV_SIZE_HI 7
`define TOVL_SV_SIZE_LO 6
`define TOVL_SV_VPOS_HI 5
`define TOVL_SV_VPOS_LO 0

// Row-0 horizontal / background fields
`define TOVL_HB_DISP 7
`define TOVL_HB_BGND 6
`define TOVL_HB_HPOS_HI 5
`define TOVL_HB_HPOS_LO 0

// AXI responses
`define TOVL_RESP_OKAY 2'h0
`define TOVL_RESP_SLVERR 2'h2

// Timing: system clock and dot rate in Hz, dot period in system cycles
`define TOVL_CLK_HZ 40000000
`define TOVL_DOT_HZ 8000000
`define TOVL_DOT_DIV (`TOVL_CLK_HZ / `TOVL_DOT_HZ)

// Row geometry: characters per row, dots per cell, lines per cell
`define TOVL_ROW_CHARS 16
`define TOVL_CELL_DOTS 8
`define TOVL_CELL_LINES 13

`endif

//--- hdl/tovl_pkg.sv
// Types shared by the text overlay row-0 control.
// No dependencies.
package tovl_pkg;

	// Dot oscillator state, gated by horizontal sync
	typedef enum logic [0:0] {
		TOVL_OSC_STOP = 1'b0,
		TOVL_OSC_RUN = 1'b1
	} tovl_osc_state_type;

	// Character size selection
	typedef logic [1:0] tovl_size_type;

endpackage

//--- hdl/tovl_axil_regs.sv
// AXI4-Lite slave holding the three overlay control registers.
// Assumes a master that keeps at most one write and one read under way.
`timescale 1ns/1ps
`include "tovl_params.svh"

module tovl_axil_regs #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] general_q,
	output logic [7:0] row0_sv_q,
	output logic [7:0] row0_hb_q
);
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic aw_held_q, aw_held_d;
	logic [7:0] wdata_q, wdata_d;
	logic w_wr_q, w_wr_d;
	logic w_held_q, w_held_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] general_d, row0_sv_d, row0_hb_d;

	// Write channels accept while their own beat is not held and no response waits; reads while no read response waits
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// Address decode and register update
	always_comb begin
		logic [ADDR_W-1:0] wa;
		wa = awaddr_q;
		awaddr_d = awaddr_q;
		aw_held_d = aw_held_q;
		wdata_d = wdata_q;
		w_wr_d = w_wr_q;
		w_held_d = w_held_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		general_d = general_q;
		row0_sv_d = row0_sv_q;
		row0_hb_d = row0_hb_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_d = s_axi_awaddr;
			aw_held_d = 1'b1;
			wa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_d = s_axi_wdata[7:0];
			w_wr_d = s_axi_wstrb[0];
			w_held_d = 1'b1;
		end
		// R16 registers read/write
		if (aw_held_d && w_held_d) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `TOVL_RESP_OKAY;
			if (wa == ADDR_W'({`TOVL_IDX_GENERAL, 2'b00})) begin
				if (w_wr_d) general_d = wdata_d;
			end else if (wa == ADDR_W'({`TOVL_IDX_ROW0_SV, 2'b00})) begin
				if (w_wr_d) row0_sv_d = wdata_d;
			end else if (wa == ADDR_W'({`TOVL_IDX_ROW0_HB, 2'b00})) begin
				if (w_wr_d) row0_hb_d = wdata_d;
			end else begin
				bresp_d = `TOVL_RESP_SLVERR;
			end
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = `TOVL_RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (s_axi_araddr == ADDR_W'({`TOVL_IDX_GENERAL, 2'b00})) begin
				rdata_d[7:0] = general_q;
			end else if (s_axi_araddr == ADDR_W'({`TOVL_IDX_ROW0_SV, 2'b00})) begin
				rdata_d[7:0] = row0_sv_q;
			end else if (s_axi_araddr == ADDR_W'({`TOVL_IDX_ROW0_HB, 2'b00})) begin
				rdata_d[7:0] = row0_hb_q;
			end else begin
				rresp_d = `TOVL_RESP_SLVERR;
			end
		end
	end

	// R16 cleared on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
			aw_held_q <= 1'b0;
			wdata_q <= 8'h00;
			w_wr_q <= 1'b0;
			w_held_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TOVL_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= `TOVL_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			general_q <= `TOVL_RST_GENERAL;
			row0_sv_q <= `TOVL_RST_ROW0_SV;
			row0_hb_q <= `TOVL_RST_ROW0_HB;
		end else begin
			awaddr_q <= awaddr_d;
			aw_held_q <= aw_held_d;
			wdata_q <= wdata_d;
			w_wr_q <= w_wr_d;
			w_held_q <= w_held_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			general_q <= general_d;
			row0_sv_q <= row0_sv_d;
			row0_hb_q <= row0_hb_d;
		end
	end

	property p_bvalid_holds;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
	endproperty
	a_bvalid_holds: assert property (p_bvalid_holds) // (R16)
		else $error("write response dropped before bready");

	property p_read_answer;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) // (R16)
		else $error("read not answered in one cycle");

endmodule

//--- hdl/tovl_dot_clock.sv
// Overlay dot clock: a divided enable that runs between horizontal sync pulses.
// Assumes the sync level is already corrected for polarity.
`timescale 1ns/1ps
`include "tovl_params.svh"

module tovl_dot_clock #(
	parameter int DIV = `TOVL_DOT_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic osc_enable,
	input wire logic hs_active,
	output logic dot_tick,
	output logic dot_first_half,
	output logic running
);
	tovl_pkg::tovl_osc_state_type state_q, state_d;
	logic hs_prev_q;
	logic [7:0] div_q, div_d;

	// Start on sync trailing edge, stop on leading edge or standby
	always_comb begin
		state_d = state_q;
		div_d = div_q;
		case (state_q)
			tovl_pkg::TOVL_OSC_STOP: begin
				div_d = 8'h00;
				// R19 start at trailing edge
				if (osc_enable && hs_prev_q && !hs_active) begin
					state_d = tovl_pkg::TOVL_OSC_RUN;
				end
			end
			tovl_pkg::TOVL_OSC_RUN: begin
				div_d = (div_q == 8'(DIV - 1)) ? 8'h00 : div_q + 8'h01;
				// R06 standby stops oscillator
				if (!osc_enable || (!hs_prev_q && hs_active)) begin
					state_d = tovl_pkg::TOVL_OSC_STOP;
				end
			end
			default: begin
				state_d = tovl_pkg::TOVL_OSC_STOP;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= tovl_pkg::TOVL_OSC_STOP;
			hs_prev_q <= 1'b0;
			div_q <= 8'h00;
		end else begin
			state_q <= state_d;
			hs_prev_q <= hs_active;
			div_q <= div_d;
		end
	end

	// Tick on last cycle of each dot period
	assign running = (state_q == tovl_pkg::TOVL_OSC_RUN);
	assign dot_tick = running && (div_q == 8'(DIV - 1));
	assign dot_first_half = div_q < 8'(DIV / 2);

	property p_standby_stops;
		@(posedge aclk) disable iff (!aresetn)
		!osc_enable |=> !running;
	endproperty
	a_standby_stops: assert property (p_standby_stops) // (R06)
		else $error("dot clock runs in standby");

	property p_stop_on_lead;
		@(posedge aclk) disable iff (!aresetn)
		(!hs_prev_q && hs_active) |=> !running;
	endproperty
	a_stop_on_lead: assert property (p_stop_on_lead) // (R19)
		else $error("dot clock not stopped at sync leading edge");

endmodule

//--- verif/tovl_video_model.sv
// Video chassis model: line and frame sync with selectable active levels.
// Assumes one aclk domain; run low parks horizontal sync at its active level.
`timescale 1ns/1ps

module tovl_video_model #(
	parameter int LINE = 60,
	parameter int HS = 8,
	parameter int FRAME = 20
) (
	input wire logic aclk,
	input wire logic run,
	input wire logic hpol,
	input wire logic vpol,
	output logic hsync,
	output logic vsync
);
	int pix = 0;
	int line = 0;

	// Position within line and frame; a stopped chassis holds the line start
	always @(posedge aclk) begin
		if (!run) begin
			pix <= 0;
		end else if (pix == LINE - 1) begin
			pix <= 0;
			line <= (line == FRAME - 1) ? 0 : line + 1;
		end else begin
			pix <= pix + 1;
		end
	end

	// Pulses sit at the programmed active level, the rest at its inverse
	assign hsync = (pix < HS) ~^ hpol;
	assign vsync = (line < 2) ~^ vpol;
endmodule

//--- verif/tovl_row0_ctrl_tb.sv
// Testbench for the overlay row-0 control: registers over AXI4-Lite, sync and dot output.
// Assumes the chassis model for sync and a bench-driven glyph dot.
`timescale 1ns/1ps

module tovl_row0_ctrl_tb;
	logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, hpol = 1'b0, vpol = 1'b0, dot = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic vertical_sync_in, horizontal_sync_in;
	logic colour_out_a, colour_out_b, colour_out_c, video_blank_out, overlay_dot_clock;
	logic ah, wh, hit, rnd = 1'b0;
	logic [4:0] s;
	logic [6:0] gx;
	logic [3:0] gl, mx;
	int lo, n, hi, cycles = 0, checks = 0, miscompares = 0;

	tovl_row0_ctrl #(.DOT_DIV(2), .ROW_CHARS(2)) dut_u (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vertical_sync_in, .horizontal_sync_in,
		.glyph_dot_in(dot | (rnd && gx == 7'h07)), .glyph_dot_above_in(rnd && gx == 7'h08),
		.glyph_x(gx), .glyph_line(gl),
		.colour_out_a, .colour_out_b, .colour_out_c, .video_blank_out, .overlay_dot_clock
	);

	tovl_video_model chassis_u (.aclk, .run, .hpol, .vpol,
		.hsync(horizontal_sync_in), .vsync(vertical_sync_in));

	// Clock and run ceiling
	initial forever #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		checks++;
		if (v !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, v);
		end
	endtask

	// Write one register, expect a response code
	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		hit = 1'b0;
		n = 0;
		while (!hit && n < 40) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready === 1'b1;
			wh = s_axi_wvalid && s_axi_wready === 1'b1;
			hit = s_axi_bvalid === 1'b1;
			if (hit) chk("bresp", er, s_axi_bresp);
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			n++;
		end
		chk("bvalid", 1'b1, hit);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Read one register, expect data and response code
	task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		hit = 1'b0;
		n = 0;
		while (!hit && n < 40) begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready === 1'b1;
			hit = s_axi_rvalid === 1'b1;
			if (hit) chk("rdata", {24'h000000, ed}, s_axi_rdata);
			if (hit) chk("rresp", er, s_axi_rresp);
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
			n++;
		end
		chk("rvalid", 1'b1, hit);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Collect which outputs went high and how often blank was low
	task automatic watch(input int c);
		s = 5'h00;
		lo = 0;
		hi = 0;
		mx = 4'h0;
		repeat (c) begin
			@(negedge aclk);
			s = s | {overlay_dot_clock, video_blank_out, colour_out_c, colour_out_b, colour_out_a};
			if (video_blank_out !== 1'b1) lo++;
			if (colour_out_a === 1'b1) hi++;
			if (colour_out_a === 1'b1 && gl > mx) mx = gl;
		end
		@(posedge aclk);
	endtask

	// Wait for the start of the next vertical sync pulse
	task automatic vs_start();
		n = 0;
		while (vertical_sync_in === vpol && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		while (vertical_sync_in !== vpol && n < 4000) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task automatic t_regs();
		for (int i = 0; i < 3; i++) rd(12'h100 + 12'(4 * i), 8'h00, 2'h0);
		rd(12'h10C, 8'h00, 2'h2);
		for (int i = 0; i < 3; i++) begin
			wr(12'h100 + 12'(4 * i), 8'hA5 + 8'(i), 2'h0);
			rd(12'h100 + 12'(4 * i), 8'hA5 + 8'(i), 2'h0);
		end
		wr(12'h110, 8'hFF, 2'h2);
		rd(12'h100, 8'hA5, 2'h0);
		for (int i = 0; i < 3; i++) wr(12'h100 + 12'(4 * i), 8'h00, 2'h0);
		$display("test registers done");
	endtask

	task automatic t_standby();
		hpol <= 1'b1;
		vpol <= 1'b1;
		wr(12'h100, 8'h07, 2'h0);
		run <= 1'b1;
		watch(1300);
		chk("dot clock standby", 1'b0, s[4]);
		wr(12'h100, 8'h03, 2'h0);
		watch(1300);
		chk("dot clock running", 1'b1, s[4]);
		run <= 1'b0;
		repeat (10) @(posedge aclk);
		watch(100);
		chk("dot clock in sync", 1'b0, s[4]);
		run <= 1'b1;
		$display("test standby done");
	endtask

	// Frame view for one row setting and glyph level
	task automatic frame(input logic [7:0] sv, input logic [7:0] hb, input logic g);
		dot <= g;
		wr(12'h104, sv, 2'h0);
		wr(12'h108, hb, 2'h0);
		vs_start();
		watch(1200);
	endtask

	task automatic t_colour();
		wr(12'h100, 8'hA3, 2'h0);
		frame(8'h01, 8'h81, 1'b1);
		chk("colours on row", 4'hD, s[3:0]);
		chk("last glyph line", 4'hC, mx);
		frame(8'h01, 8'h01, 1'b1);
		chk("display off", 4'h0, s[3:0]);
		frame(8'h01, 8'hC1, 1'b0);
		chk("background box", 4'h8, s[3:0]);
		frame(8'h01, 8'h81, 1'b0);
		chk("no background", 4'h0, s[3:0]);
		frame(8'h3F, 8'h81, 1'b1);
		chk("row below frame", 4'h0, s[3:0]);
		frame(8'h01, 8'hBF, 1'b1);
		chk("row beyond line", 4'h0, s[3:0]);
		$display("test colour done");
	endtask

	// One dot at column 7, its diagonal partner above column 8 across the cell edge
	task automatic t_round();
		rnd <= 1'b1;
		frame(8'h01, 8'h81, 1'b0);
		chk("plain dot cycles", 26, hi);
		wr(12'h100, 8'hAB, 2'h0);
		frame(8'h01, 8'h81, 1'b0);
		chk("rounded dot cycles", 39, hi);
		wr(12'h100, 8'hA3, 2'h0);
		frame(8'h41, 8'h81, 1'b0);
		chk("double size dot cycles", 72, hi);
		rnd <= 1'b0;
		$display("test rounding done");
	endtask

	task automatic t_blank();
		hpol <= 1'b0;
		vpol <= 1'b0;
		wr(12'h100, 8'h10, 2'h0);
		wr(12'h108, 8'h00, 2'h0);
		repeat (3) @(posedge aclk);
		watch(1300);
		chk("blank forced", 0, lo);
		vs_start();
		wr(12'h100, 8'h00, 2'h0);
		watch(20);
		chk("blank held", 0, lo);
		n = 0;
		while (vertical_sync_in !== 1'b1 && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		repeat (4) @(posedge aclk);
		watch(100);
		chk("blank released", 1'b0, s[3]);
		$display("test blank done");
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Reset, then the scenarios in order
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_standby();
		t_colour();
		t_round();
		t_blank();
		summarize();
	end
endmodule
